// [rtl/frc_defs.svh]
// constants of the reset, mode and replay control of the dual-clock fifo
// assumes inclusion by the package and by the design files that need numbers
`ifndef FRC_DEFS_SVH
`define FRC_DEFS_SVH

`define FRC_DW        9
`define FRC_AW        14
`define FRC_PW        15
`define FRC_OW        14
`define FRC_MSB_W     5
`define FRC_DEPTH     15'h4000
`define FRC_HALF      15'h2000
`define FRC_OFF_PAR   14'h007f
`define FRC_OFF_SER   14'h03ff
`define FRC_SLOT_ELSB 2'h0
`define FRC_SLOT_EMSB 2'h1
`define FRC_SLOT_FLSB 2'h2
`define FRC_SLOT_FMSB 2'h3

`endif

// [rtl/frc_pkg.sv]
// types and pointer codecs shared by the fifo control and its memory
// assumes frc_defs.svh on the include path
package frc_pkg;
`include "frc_defs.svh"

    typedef logic [`FRC_DW-1:0] frc_word_t;
    typedef logic [`FRC_PW-1:0] frc_ptr_t;
    typedef logic [`FRC_OW-1:0] frc_off_t;

    // read side phase: normal running or replay setup
    typedef enum logic {RD_RUN, RD_REPLAY} frc_rph_t;

    // write side configuration, kept across soft clear
    typedef struct packed {
        logic       fall_through_mode;
        logic       ser;
        frc_off_t   foff;
        frc_off_t   eoff;
        logic [1:0] opw;
    } frc_wcfg_t;

    // write side pointer and flag state
    typedef struct packed {
        frc_ptr_t wbin;
        frc_ptr_t wgray;
        frc_ptr_t rg1;
        frc_ptr_t rg2;
        logic     full;
        logic     afull;
        logic     hft;
        logic     hf1;
        logic     hf2;
    } frc_wst_t;

    // read side pointer, output and flag state
    typedef struct packed {
        frc_ptr_t  rbin;
        frc_ptr_t  rgray;
        frc_ptr_t  wg1;
        frc_ptr_t  wg2;
        frc_word_t dout;
        logic      avail;
        logic      aempty;
        logic      hft;
        logic      hf1;
        logic      hf2;
        logic      m1;
        logic      m2;
        logic      ld1;
        logic      ld2;
        frc_rph_t  ph;
    } frc_rst_t;

    // read side offset readback state, kept across soft clear
    typedef struct packed {
        logic [1:0]           orp;
        logic [2*`FRC_OW-1:0] o1;
        logic [2*`FRC_OW-1:0] o2;
    } frc_rcfg_t;

    function automatic frc_ptr_t frc_b2g(input frc_ptr_t b);
        return b ^ (b >> 1);
    endfunction

    function automatic frc_ptr_t frc_g2b(input frc_ptr_t g);
        frc_ptr_t b;
        b = g;
        for (int i = `FRC_PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

endpackage

// [rtl/frc_ram.sv]
// fifo storage: written on the write clock, read without a clock
// assumes the caller registers the read data in its own domain
`timescale 1ns/1ps
`include "frc_defs.svh"
module frc_ram
    import frc_pkg::*;
(
    input  wire logic                 wclk,
    input  wire logic                 we,
    input  wire logic [`FRC_AW-1:0]   waddr,
    input  wire frc_word_t            wdata,
    input  wire logic [`FRC_AW-1:0]   raddr,
    output frc_word_t                 rdata
);

    frc_word_t mem [0:(1 << `FRC_AW) - 1];

    // write port; the pointers keep reader and writer off the same word
    always_ff @(posedge wclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule

// [rtl/frc_ctrl.sv]
// reset, mode, offset and replay control of a 16384 x 9 dual-clock fifo
// assumes writer logic on MCLK and reader logic on RCLK; clears are async
`timescale 1ns/1ps
`include "frc_defs.svh"
module frc_ctrl
    import frc_pkg::*;
(
    input  wire logic      MCLK,
    input  wire logic      RST_B,
    input  wire logic      RCLK,
    input  wire logic      FULL_CLEAR_N,
    input  wire logic      SOFT_CLEAR_N,
    input  wire logic      REPLAY_N,
    input  wire logic      FALLTHRU_SEL_SERIAL_IN,
    input  wire logic      LOAD_SEL_N,
    input  wire logic      WR_EN_N,
    input  wire logic      RD_EN_N,
    input  wire logic      SER_EN_N,
    input  wire frc_word_t DIN,
    output frc_word_t      DOUT,
    output logic           FULL_IR_N,
    output logic           EMPTY_OR_N,
    output logic           ALMOST_EMPTY_N,
    output logic           ALMOST_FULL_N,
    output logic           HALF_FULL_N
);

    localparam frc_wst_t  W_RST  = '0;
    localparam frc_rst_t  R_RST  = '0;
    localparam frc_wcfg_t WC_RST = '{fall_through_mode: 1'b0, ser: 1'b0, foff: `FRC_OFF_PAR,
                                     eoff: `FRC_OFF_PAR, opw: `FRC_SLOT_ELSB};

    frc_wst_t  ws_r;
    frc_wst_t  ws_nxt;
    frc_wcfg_t wc_r;
    frc_wcfg_t wc_nxt;
    frc_rst_t  rs_r;
    frc_rst_t  rs_nxt;
    frc_rcfg_t rc_r;
    frc_rcfg_t rc_nxt;
    logic [1:0] wfc_q;
    logic [1:0] wrs_q;
    logic [1:0] rfc_q;
    logic [1:0] rrs_q;
    logic       wfc_n;
    logic       wrst_n;
    logic       rfc_n;
    logic       rrst_n;
    logic       any_clr_n;
    logic       wr_go;
    frc_ptr_t   rbin_s;
    frc_ptr_t   wcnt;
    frc_ptr_t   wbin_s;
    frc_ptr_t   rcnt;
    frc_word_t  ram_q;
    logic       rfwft;
    logic       rd_go;
    logic       empty;

    assign any_clr_n = FULL_CLEAR_N & SOFT_CLEAR_N;

    // clears assert at once and release on each domain's own edge
    always_ff @(posedge MCLK or negedge FULL_CLEAR_N) begin
        if (!FULL_CLEAR_N) begin
            wfc_q <= 2'h0;
        end else begin
            wfc_q <= {wfc_q[0], 1'b1};
        end
    end

    always_ff @(posedge MCLK or negedge any_clr_n) begin
        if (!any_clr_n) begin
            wrs_q <= 2'h0;
        end else begin
            wrs_q <= {wrs_q[0], 1'b1};
        end
    end

    always_ff @(posedge RCLK or negedge FULL_CLEAR_N) begin
        if (!FULL_CLEAR_N) begin
            rfc_q <= 2'h0;
        end else begin
            rfc_q <= {rfc_q[0], 1'b1};
        end
    end

    always_ff @(posedge RCLK or negedge any_clr_n) begin
        if (!any_clr_n) begin
            rrs_q <= 2'h0;
        end else begin
            rrs_q <= {rrs_q[0], 1'b1};
        end
    end

    assign wfc_n  = wfc_q[1];
    assign wrst_n = wrs_q[1];
    assign rfc_n  = rfc_q[1];
    assign rrst_n = rrs_q[1];

    // storage; writes while load select is low go to the offsets in parallel mode, nowhere in serial
    assign wr_go = !WR_EN_N && LOAD_SEL_N && !ws_r.full;

    frc_ram u_ram (
        .wclk  (MCLK),
        .we    (wr_go),
        .waddr (ws_r.wbin[`FRC_AW-1:0]),
        .wdata (DIN),
        .raddr (rs_r.rbin[`FRC_AW-1:0]),
        .rdata (ram_q)
    );

    // write side: pointer, full, almost-full and half-full assertion
    always_comb begin
        ws_nxt = ws_r;
        wc_nxt = wc_r;
        ws_nxt.rg1 = rs_r.rgray;
        ws_nxt.rg2 = ws_r.rg1;
        ws_nxt.hf1 = rs_r.hft;
        ws_nxt.hf2 = ws_r.hf1;
        rbin_s = frc_g2b(ws_r.rg2);
        if (wr_go) begin
            ws_nxt.wbin = ws_r.wbin + 15'h0001;
        end
        ws_nxt.wgray = frc_b2g(ws_nxt.wbin);
        wcnt = ws_nxt.wbin - rbin_s;
        // flags move only on write edges, so a stopped clock freezes them
        ws_nxt.full  = (wcnt == `FRC_DEPTH);
        ws_nxt.afull = (wcnt >= (`FRC_DEPTH - {1'b0, wc_r.foff}));
        // only a rise is made here; the read side does the release
        if (ws_r.hft == ws_r.hf2 && wcnt > `FRC_HALF) begin
            ws_nxt.hft = !ws_r.hft;
        end
        // configuration: defaults track the pins until full clear lets go
        if (!wfc_n) begin
            wc_nxt.fall_through_mode = FALLTHRU_SEL_SERIAL_IN;
            wc_nxt.ser  = LOAD_SEL_N;
            wc_nxt.eoff = LOAD_SEL_N ? `FRC_OFF_SER : `FRC_OFF_PAR;
            wc_nxt.foff = LOAD_SEL_N ? `FRC_OFF_SER : `FRC_OFF_PAR;
            wc_nxt.opw  = `FRC_SLOT_ELSB;
        end else if (wrst_n && !LOAD_SEL_N) begin
            if (wc_r.ser && !SER_EN_N) begin
                // serial: shift in at the top, first bit lands in empty lsb
                {wc_nxt.foff, wc_nxt.eoff} =
                    {FALLTHRU_SEL_SERIAL_IN, wc_r.foff, wc_r.eoff[`FRC_OW-1:1]};
            end else if (!wc_r.ser && !WR_EN_N) begin
                case (wc_r.opw)
                    `FRC_SLOT_ELSB: wc_nxt.eoff[8:0] = DIN;
                    `FRC_SLOT_EMSB: wc_nxt.eoff[`FRC_OW-1:9] = DIN[`FRC_MSB_W-1:0];
                    `FRC_SLOT_FLSB: wc_nxt.foff[8:0] = DIN;
                    default:        wc_nxt.foff[`FRC_OW-1:9] = DIN[`FRC_MSB_W-1:0];
                endcase
                wc_nxt.opw = wc_r.opw + 2'h1;
            end
        end
    end

    // write side registers; soft clear leaves the configuration alone
    always_ff @(posedge MCLK or negedge wrst_n) begin
        if (!wrst_n) begin
            ws_r <= W_RST;
        end else if (!RST_B) begin
            ws_r <= W_RST;
        end else begin
            ws_r <= ws_nxt;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            wc_r <= WC_RST;
        end else begin
            wc_r <= wc_nxt;
        end
    end

    // read side: fetch, fall-through, replay, offset readback, flags
    always_comb begin
        rs_nxt = rs_r;
        rc_nxt = rc_r;
        rs_nxt.wg1 = ws_r.wgray;
        rs_nxt.wg2 = rs_r.wg1;
        rs_nxt.hf1 = ws_r.hft;
        rs_nxt.hf2 = rs_r.hf1;
        rs_nxt.m1  = wc_r.fall_through_mode;
        rs_nxt.m2  = rs_r.m1;
        rs_nxt.ld1 = LOAD_SEL_N;
        rs_nxt.ld2 = rs_r.ld1;
        rc_nxt.o1  = {wc_r.foff, wc_r.eoff};
        rc_nxt.o2  = rc_r.o1;
        rfwft  = rs_r.m2;
        wbin_s = frc_g2b(rs_r.wg2);
        empty  = (wbin_s == rs_r.rbin);
        rd_go  = !RD_EN_N && rs_r.ld2;
        if (!rfc_n) begin
            rc_nxt.orp = `FRC_SLOT_ELSB;
        end else if (!RD_EN_N && !rs_r.ld2) begin
            // offset readback overwrites the output word, as the user expects
            case (rc_r.orp)
                `FRC_SLOT_ELSB: rs_nxt.dout = rc_r.o2[8:0];
                `FRC_SLOT_EMSB: rs_nxt.dout = {4'h0, rc_r.o2[`FRC_OW-1:9]};
                `FRC_SLOT_FLSB: rs_nxt.dout = rc_r.o2[`FRC_OW+8:`FRC_OW];
                default:        rs_nxt.dout = {4'h0, rc_r.o2[2*`FRC_OW-1:`FRC_OW+9]};
            endcase
            rc_nxt.orp = rc_r.orp + 2'h1;
        end
        case (rs_r.ph)
            RD_REPLAY: begin
                if (REPLAY_N) begin
                    rs_nxt.ph = RD_RUN;
                end
            end
            default: begin
                if (!rfwft) begin
                    if (rd_go && !empty) begin
                        rs_nxt.dout = ram_q;
                        rs_nxt.rbin = rs_r.rbin + 15'h0001;
                    end
                end else if ((!rs_r.avail || rd_go) && !empty) begin
                    rs_nxt.dout  = ram_q;
                    rs_nxt.rbin  = rs_r.rbin + 15'h0001;
                    rs_nxt.avail = 1'b1;
                end else if (rd_go && rs_r.avail) begin
                    rs_nxt.avail = 1'b0;
                end
            end
        endcase
        // replay setup wins over any fetch in the same edge
        if (!REPLAY_N) begin
            rs_nxt.rbin  = '0;
            rs_nxt.avail = 1'b0;
            rs_nxt.ph    = RD_REPLAY;
        end else if (!rfwft && rs_r.ph == RD_RUN) begin
            rs_nxt.avail = (wbin_s != rs_nxt.rbin);
        end
        rs_nxt.rgray = frc_b2g(rs_nxt.rbin);
        rcnt = wbin_s - rs_nxt.rbin + {14'h0, rfwft & rs_nxt.avail};
        rs_nxt.aempty = (rcnt <= {1'b0, rc_r.o2[`FRC_OW-1:0]});
        // the release of half-full belongs to this side alone
        if (rs_r.hft != rs_r.hf2 && rcnt <= `FRC_HALF) begin
            rs_nxt.hft = !rs_r.hft;
        end
    end

    // read side registers; clears zero the output word without a clock
    always_ff @(posedge RCLK or negedge rrst_n) begin
        if (!rrst_n) begin
            rs_r <= '{aempty: 1'b1, ph: RD_RUN, default: '0};
        end else begin
            rs_r <= rs_nxt;
        end
    end

    always_ff @(posedge RCLK) begin
        rc_r <= rc_nxt;
    end

    // pins: one flop per flag but half-full, an xor of two toggles; mode picks the polarity of the shared pins
    assign DOUT           = rs_r.dout;
    assign FULL_IR_N      = wc_r.fall_through_mode ? ws_r.full : !ws_r.full;
    // mode from the write-side copy: the read copy is wiped by every clear
    assign EMPTY_OR_N     = wc_r.fall_through_mode ? !rs_r.avail : rs_r.avail;
    assign ALMOST_EMPTY_N = !rs_r.aempty;
    assign ALMOST_FULL_N  = !ws_r.afull;
    // both toggles equal means released; the xor only ever moves one input
    assign HALF_FULL_N    = !(ws_r.hft ^ rs_r.hft);

    chk_full_clr_pins: assert property (@(posedge MCLK) disable iff (!RST_B)
        !FULL_CLEAR_N |-> !ALMOST_EMPTY_N && ALMOST_FULL_N && HALF_FULL_N && DOUT == '0)
        else $error("full clear levels wrong");

    chk_soft_clr_pins: assert property (@(posedge MCLK) disable iff (!RST_B)
        !SOFT_CLEAR_N |-> !ALMOST_EMPTY_N && ALMOST_FULL_N && HALF_FULL_N && DOUT == '0)
        else $error("soft clear levels wrong");

    chk_clr_mode_flags: assert property (@(posedge MCLK) disable iff (!RST_B)
        !SOFT_CLEAR_N |-> EMPTY_OR_N == wc_r.fall_through_mode && FULL_IR_N == !wc_r.fall_through_mode)
        else $error("clear flag levels ignore mode");

    chk_default_offsets: assert property (@(posedge MCLK) disable iff (!RST_B)
        $rose(wfc_n) |-> wc_r.eoff == (wc_r.ser ? `FRC_OFF_SER : `FRC_OFF_PAR)
            && wc_r.foff == wc_r.eoff && wc_r.opw == `FRC_SLOT_ELSB)
        else $error("default offsets wrong after full clear");

    chk_soft_keeps_cfg: assert property (@(posedge MCLK) disable iff (!RST_B)
        (!wrst_n && wfc_n) |=> $stable(wc_r))
        else $error("soft clear disturbed configuration");

    chk_serial_shift: assert property (@(posedge MCLK) disable iff (!RST_B)
        (wfc_n && wrst_n && wc_r.ser && !LOAD_SEL_N && !SER_EN_N)
            |=> wc_r.foff[`FRC_OW-1] == $past(FALLTHRU_SEL_SERIAL_IN))
        else $error("serial offset bit not taken");

    chk_full_blocks: assert property (@(posedge MCLK) disable iff (!wrst_n || !RST_B)
        ws_r.full |=> ws_r.wbin == $past(ws_r.wbin))
        else $error("write taken while full");

    chk_hf_wr_rise: assert property (@(posedge MCLK) disable iff (!wrst_n || !RST_B)
        $changed(ws_r.hft) |-> $past(ws_r.hft == ws_r.hf2))
        else $error("write side released half-full");

    chk_replay_home: assert property (@(posedge RCLK) disable iff (!rrst_n)
        !REPLAY_N |=> rs_r.rbin == '0 && !rs_r.avail && rs_r.ph == RD_REPLAY)
        else $error("replay did not home read pointer");

    chk_fall_through_mode_fall: assert property (@(posedge RCLK) disable iff (!rrst_n)
        (rfwft && !rs_r.avail && !empty && REPLAY_N && rs_r.ph == RD_RUN)
            |=> !EMPTY_OR_N && rs_r.rbin == $past(rs_r.rbin) + 15'h0001)
        else $error("first word did not fall through");

    chk_std_needs_ren: assert property (@(posedge RCLK) disable iff (!rrst_n)
        (!rfwft && RD_EN_N && REPLAY_N) |=> $stable(rs_r.rbin))
        else $error("read pointer moved without read enable");

endmodule

// [tb/frc_rd_model.sv]
// reader-side partner of the fifo control: makes the read clock and drives
// the read enable and replay pins; assumes the bench asks through rd_req/rp_req
`timescale 1ns/1ps
module frc_rd_model (
    input  wire logic rd_req,
    input  wire logic rp_req,
    output logic      RCLK,
    output logic      RD_EN_N,
    output logic      REPLAY_N
);
    // 64 ns read clock, offset so its edges never meet the write clock's
    initial begin
        RCLK = 1'b0;
        #13;
        forever begin
            #32 RCLK = ~RCLK;
        end
    end

    // pins move only just after a read edge; replay waits for reads to stop
    initial begin
        RD_EN_N = 1'b1;
        REPLAY_N = 1'b1;
        forever begin
            @(posedge RCLK);
            RD_EN_N <= ~(rd_req && !rp_req);
            REPLAY_N <= ~(rp_req && RD_EN_N);
        end
    end
endmodule

// [tb/frc_ctrl_tb_top.sv]
// self-checking bench of the fifo reset, mode and replay control
// assumes frc_pkg compiled first and frc_rd_model as the reader partner
`timescale 1ns/1ps
`include "frc_defs.svh"
module frc_ctrl_tb_top;
    import frc_pkg::*;
    logic      MCLK, RST_B, RCLK, FULL_CLEAR_N, SOFT_CLEAR_N, REPLAY_N;
    logic      FALLTHRU_SEL_SERIAL_IN, LOAD_SEL_N, WR_EN_N, RD_EN_N, SER_EN_N;
    logic      FULL_IR_N, EMPTY_OR_N, ALMOST_EMPTY_N, ALMOST_FULL_N, HALF_FULL_N;
    logic      rd_req, rp_req;
    frc_word_t DIN, DOUT;
    frc_word_t q[$];
    frc_word_t pw[4];
    frc_off_t  eo, fo;
    logic [27:0] sb;
    int        n_fail, compares, k, n;

    frc_ctrl dut (.MCLK(MCLK), .RST_B(RST_B), .RCLK(RCLK), .FULL_CLEAR_N(FULL_CLEAR_N),
        .SOFT_CLEAR_N(SOFT_CLEAR_N), .REPLAY_N(REPLAY_N),
        .FALLTHRU_SEL_SERIAL_IN(FALLTHRU_SEL_SERIAL_IN), .LOAD_SEL_N(LOAD_SEL_N),
        .WR_EN_N(WR_EN_N), .RD_EN_N(RD_EN_N), .SER_EN_N(SER_EN_N), .DIN(DIN), .DOUT(DOUT),
        .FULL_IR_N(FULL_IR_N), .EMPTY_OR_N(EMPTY_OR_N), .ALMOST_EMPTY_N(ALMOST_EMPTY_N),
        .ALMOST_FULL_N(ALMOST_FULL_N), .HALF_FULL_N(HALF_FULL_N));

    frc_rd_model rdm (.rd_req(rd_req), .rp_req(rp_req), .RCLK(RCLK), .RD_EN_N(RD_EN_N),
        .REPLAY_N(REPLAY_N));

    // 125 MHz write clock
    initial MCLK = 1'b0;
    always #4 MCLK = ~MCLK;

    // verdict in one place; also reached from any wait that runs out
    task automatic wrap_up();
        $display("counts: %0d compares, %0d failures", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input frc_word_t got, input frc_word_t exp, input string m);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask

    // expected offset slot contents: lsb slots 9 bits, msb slots zero-extended
    function automatic frc_word_t off_slot(input frc_off_t o, input int s);
        return (s % 2 == 0) ? o[8:0] : {4'h0, o[13:9]};
    endfunction

    // reset levels of all flags; the dual-purpose pair depends on the mode
    task automatic chk_clear(input logic ft);
        chk(ALMOST_EMPTY_N, 9'h000, "almost-empty in clear");
        chk(ALMOST_FULL_N, 9'h001, "almost-full in clear");
        chk(HALF_FULL_N, 9'h001, "half-full in clear");
        chk(EMPTY_OR_N, {8'h00, ft}, "empty/ready in clear");
        chk(FULL_IR_N, {8'h00, ~ft}, "full/room in clear");
        chk(DOUT, 9'h000, "output word in clear");
    endtask

    // pins held through the clear and a few cycles past release
    task automatic fclr(input logic ft, input logic ld);
        @(posedge MCLK);
        FULL_CLEAR_N <= 1'b0;
        FALLTHRU_SEL_SERIAL_IN <= ft;
        LOAD_SEL_N <= ld;
        repeat (4) @(posedge RCLK);
        #1 chk_clear(ft);
        @(posedge MCLK) FULL_CLEAR_N <= 1'b1;
        repeat (4) @(posedge MCLK);
        LOAD_SEL_N <= 1'b1;
        FALLTHRU_SEL_SERIAL_IN <= 1'b0;
        repeat (4) @(posedge RCLK);
    endtask

    task automatic sclr(input logic ft);
        @(posedge MCLK) SOFT_CLEAR_N <= 1'b0;
        repeat (4) @(posedge RCLK);
        #1 chk_clear(ft);
        @(posedge MCLK) SOFT_CLEAR_N <= 1'b1;
        repeat (4) @(posedge RCLK);
    endtask

    task automatic set_ld(input logic v);
        @(posedge MCLK) LOAD_SEL_N <= v;
        repeat (3) @(posedge RCLK);
    endtask

    task automatic wr(input frc_word_t w);
        @(posedge MCLK);
        WR_EN_N <= 1'b0;
        DIN <= w;
        @(posedge MCLK);
        WR_EN_N <= 1'b1;
    endtask

    // one read strobe through the partner, then look at the held word
    task automatic rd1(input frc_word_t e, input string m);
        @(posedge RCLK) rd_req <= 1'b1;
        @(posedge RCLK) rd_req <= 1'b0;
        repeat (2) @(posedge RCLK);
        #1 chk(DOUT, e, m);
    endtask

    // bounded wait for the empty/ready pin; k counts read edges taken
    task automatic wait_eor(input logic v, output int c);
        for (c = 1; c <= 40; c++) begin
            @(posedge RCLK);
            #1;
            if (EMPTY_OR_N === v)
                return;
        end
        n_fail++;
        $display("CHECK FAILED t=%0t empty/ready wait ran out", $time);
        wrap_up();
    endtask

    // setup flag shows on the same edge that samples the replay
    task automatic replay(input logic ft);
        @(posedge RCLK) rp_req <= 1'b1;
        repeat (3) @(posedge RCLK);
        #1 chk(EMPTY_OR_N, {8'h00, ft}, "replay setup flag");
        @(posedge RCLK) rp_req <= 1'b0;
    endtask

    initial begin
        n_fail = 0;
        compares = 0;
        {FULL_CLEAR_N, SOFT_CLEAR_N, WR_EN_N, SER_EN_N, LOAD_SEL_N} = 5'h1f;
        FALLTHRU_SEL_SERIAL_IN = 1'b0;
        DIN = 9'h000;
        rd_req = 1'b0;
        rp_req = 1'b0;
        RST_B = 1'b0;
        void'($urandom(32'hd9c27a90));
        repeat (5) @(posedge MCLK);
        RST_B <= 1'b1;

        // flagged mode, parallel offsets, default readback
        fclr(1'b0, 1'b0);
        set_ld(1'b0);
        for (int s = 0; s < 4; s++) begin
            rd1(off_slot(`FRC_OFF_PAR, s), "parallel default offset");
        end
        // program all four slots in parallel, then read them back in order
        for (int s = 0; s < 4; s++) begin
            pw[s] = frc_word_t'($urandom);
            wr(pw[s]);
        end
        eo = {pw[1][4:0], pw[0]};
        fo = {pw[3][4:0], pw[2]};
        for (int s = 0; s < 4; s++) begin
            rd1(off_slot((s < 2) ? eo : fo, s), "parallel programmed offset");
        end
        set_ld(1'b1);
        $display("test done: flagged mode defaults");

        // random burst, read back, then replay from the start
        n = 3 + $urandom % 6;
        for (int i = 0; i < n; i++) begin
            q.push_back(frc_word_t'($urandom));
            wr(q[i]);
        end
        wait_eor(1'b1, k);
        for (int i = 0; i < n; i++) begin
            rd1(q[i], "flagged read");
        end
        replay(1'b0);
        wait_eor(1'b1, k);
        rd1(q[0], "first word after replay");
        rd1(q[1], "second word after replay");
        $display("test done: flagged replay");

        sclr(1'b0);
        $display("test done: flagged soft clear");

        // fall-through mode, serial offsets; slot pointer survives soft clear
        fclr(1'b1, 1'b1);
        set_ld(1'b0);
        rd1(off_slot(`FRC_OFF_SER, 0), "serial default offset lsb");
        set_ld(1'b1);
        sclr(1'b1);
        set_ld(1'b0);
        rd1(off_slot(`FRC_OFF_SER, 1), "offset slot after soft clear");
        // shift 28 random bits; the first one ends in the empty offset lsb
        sb = 28'($urandom);
        @(posedge MCLK);
        SER_EN_N <= 1'b0;
        for (int i = 0; i < 28; i++) begin
            FALLTHRU_SEL_SERIAL_IN <= sb[i];
            @(posedge MCLK);
        end
        SER_EN_N <= 1'b1;
        FALLTHRU_SEL_SERIAL_IN <= 1'b0;
        eo = sb[13:0];
        fo = sb[27:14];
        // slot pointer stands at the full lsb after the two reads above
        for (int s = 2; s < 6; s++) begin
            rd1(off_slot((s % 4 < 2) ? eo : fo, s % 4), "serial offset");
        end
        set_ld(1'b1);
        $display("test done: serial defaults and soft clear");

        // first word falls through on the third read edge
        q.delete();
        q.push_back(frc_word_t'($urandom));
        q.push_back(9'h1ff);
        wr(q[0]);
        wait_eor(1'b0, k);
        chk(frc_word_t'(k), 9'h003, "fall-through latency");
        chk(DOUT, q[0], "fall-through first word");
        wr(q[1]);
        repeat (6) @(posedge RCLK);
        replay(1'b1);
        wait_eor(1'b0, k);
        chk(DOUT, q[0], "fall-through word after replay");
        rd1(q[1], "fall-through second word");
        $display("test done: fall-through replay");
        wrap_up();
    end
endmodule
